// ### inc/fault_prot_pkg.sv
// Constants of the port fault-protection block: register offsets, field
// positions, reset values and the blanking-time base.
// Assumes the 40 MHz device clock; the bench repeats these numbers as literals and sets its own blanking unit.
package fault_prot_pkg;
	// Clock rate
	localparam int unsigned CLK_HZ = 40_000_000;

	// Register offsets
	localparam logic [7:0] OFS_FAULT_STATUS_MASK  = 8'h15;
	localparam logic [7:0] OFS_FAULT_CONTROL      = 8'h1B;
	localparam logic [7:0] OFS_POWER_CONTROL      = 8'h1C;
	localparam logic [7:0] OFS_FAULT_STATUS       = 8'h1F;
	localparam logic [7:0] OFS_SINK_DISC_THRESH   = 8'h72;
	localparam logic [7:0] OFS_EXTRA_STATUS       = 8'hA0;
	localparam logic [7:0] OFS_EXTRA_STATUS_MASK  = 8'hA2;
	localparam logic [7:0] OFS_VBUS_PROT_CONFIG   = 8'hA4;
	localparam logic [7:0] OFS_VCONN_PROT_CONFIG  = 8'hA6;
	localparam logic [7:0] OFS_FAULT_OUTPUT_SEL   = 8'hA8;

	// Reset values
	localparam logic [7:0]  RST_FAULT_STATUS_MASK = 8'hFF;
	localparam logic [7:0]  RST_FAULT_CONTROL     = 8'h07;
	localparam logic [7:0]  RST_POWER_CONTROL     = 8'h00;
	localparam logic [15:0] RST_SINK_DISC_THRESH  = 16'h0000;
	localparam logic [15:0] RST_EXTRA_MASK        = 16'hFFFF;
	localparam logic [15:0] RST_VBUS_PROT_CONFIG  = 16'h0050;
	localparam logic [15:0] RST_VCONN_PROT_CONFIG = 16'h0008;
	localparam logic [15:0] RST_FAULT_OUTPUT_SEL  = 16'h0000;

	// fault_control fields (enables)
	localparam int FC_VCONN_OC_EN = 0;
	localparam int FC_VBUS_OV_EN  = 1;
	localparam int FC_VBUS_OC_EN  = 2;
	// power_control fields
	localparam int PC_VCONN_SUPPLY_ON = 0;
	// fault_status fields
	localparam int FS_VCONN_OC = 1;
	localparam int FS_VBUS_OV  = 2;
	localparam int FS_VBUS_OC  = 3;
	// extra_status fields
	localparam int XS_SRC_UV   = 0;
	localparam int XS_SRC_RV   = 1;
	localparam int XS_VCONN_OV = 2;
	localparam int XS_VCONN_UV = 3;
	localparam int XS_VCONN_OT = 4;
	localparam int XS_VCONN_RV = 5;
	// vbus_protection_config fields
	localparam int VB_OC_THR_LSB  = 0;  // 0:3.6A 1:1.8A 2:4.8A 3:6.0A
	localparam int VB_OV_THR_LSB  = 2;  // 0:default 1:standard max 2:extended max
	localparam int VB_OV_EN       = 4;
	localparam int VB_UV_DISABLE  = 5;
	localparam int VB_RV_EN       = 6;
	localparam int VB_UV_BLANK_LSB = 8;
	// vconn_protection_config fields
	localparam int VC_OC_THR_LSB   = 0; // 0:400mA 1:600mA 2:800mA
	localparam int VC_UV_DISABLE   = 2;
	localparam int VC_OT_EN        = 3;
	localparam int VC_UV_BLANK_LSB = 4;
	// fault_output_select fields
	localparam int SEL_VBUS_OC  = 0;
	localparam int SEL_VBUS_OV  = 1;
	localparam int SEL_SRC_UV   = 2;
	localparam int SEL_VBUS_UV  = 3;
	localparam int SEL_VBUS_RV  = 4;
	localparam int SEL_VCONN_OC = 5;
	localparam int SEL_VCONN_OV = 6;
	localparam int SEL_VCONN_UV = 7;
	localparam int SEL_VCONN_OT = 8;
	localparam int SEL_VCONN_RV = 9;

	// Overvoltage threshold codes and the highest legal VCONN overcurrent code
	localparam logic [1:0] OV_THR_DEFAULT  = 2'h0;
	localparam logic [1:0] OV_THR_STD_MAX  = 2'h1;
	localparam logic [1:0] OV_THR_EXT_MAX  = 2'h2;
	localparam logic [1:0] VC_OC_THR_MAXCD = 2'h2;

	// Undervoltage blanking: (select + 1) units of this time
	localparam int unsigned UV_BLANK_UNIT_US  = 1000;
	localparam int unsigned UV_BLANK_UNIT_CYC = UV_BLANK_UNIT_US * (CLK_HZ / 1_000_000);
endpackage

// ### src/usbc_port_fault_protection.sv
// Fault-protection logic of a Type-C port: comparator events in, gate, discharge,
// supply and fault-pin actions out, registers on a simple byte-address port.
// Assumes comparator inputs synchronous to SYS_CLK_IN and transport outside.
// Function
// [R1] Overcurrent from current sense or GPIO counts as VBUS overcurrent when enabled.
// [R2] Source-role VBUS faults, VCONN heat or reverse: source gate off, then discharge.
// [R3] Sink-role overcurrent, overvoltage, VCONN heat or reverse: sink gate off.
// [R4] VBUS overcurrent sets its status bit; fault pin only when selected.
// [R5] Any VBUS fault with VCONN on: mux off, discharge, clear supply enable.
// [R6] VBUS overcurrent threshold selectable, 3.6A default, 1.8A, 4.8A, 6.0A.
// [R7] Enabled VBUS overvoltage sets its status bit; fault pin when selected.
// [R8] Overvoltage threshold: three codes as source, two as sink.
// [R9] Enabled source undervoltage sets its extra bit; fault pin when selected.
// [R10] Source undervoltage sets VBUS overcurrent bit when its enable is off and selected.
// [R11] Source undervoltage ignored from VBUS enable until blanking time ends.
// [R12] No sink undervoltage; sink disconnect compares VBUS against threshold register.
// [R13] Enabled source reverse voltage sets its extra bit; fault pin when selected.
// [R14] Reverse voltage sets VBUS overcurrent bit when enabled and selected.
// [R15] Manager disables reverse protection when path selects are equal.
// [R16] VCONN overcurrent: supply off, discharge, status bit, pin if selected.
// [R17] VCONN overcurrent threshold selectable, 400mA default, 600mA, 800mA.
// [R18] VCONN overvoltage: supply off, discharge, extra bit, pin, overcurrent bit.
// [R19] VCONN undervoltage: supply off, discharge, extra bit, pin, overcurrent bit.
// [R20] VCONN undervoltage ignored from VCONN enable until blanking time ends.
// [R21] VCONN over-temperature: supply off, VBUS gate off, extra bit, pin.
// [R22] VCONN reverse voltage: supply off, VBUS gate off, bits, pin.
// [R23] Fault pin released only when both status registers are clear.
// [R24] Status bits stick until cleared; unmasked set bits raise alert.
// [R25] Simultaneous faults all take every applicable action and status.
`timescale 1ns/1ps
module usbc_port_fault_protection #(
	parameter int unsigned UV_BLANK_UNIT_CYC = fault_prot_pkg::UV_BLANK_UNIT_CYC
) (
	input  wire logic        SYS_CLK_IN,
	input  wire logic        SYS_RST_IN,
	input  wire logic [7:0]  REG_ADDR_IN,
	input  wire logic [15:0] REG_WDATA_IN,
	input  wire logic        REG_WR_IN,
	input  wire logic        REG_RD_IN,
	output logic      [15:0] REG_RDATA_OUT,
	input  wire logic        SRC_GATE_REQ_IN,
	input  wire logic        SNK_GATE_REQ_IN,
	input  wire logic        CURRENT_SENSE_PAIR_OC_IN,
	input  wire logic        GPIO_OC_IN,
	input  wire logic        VBUS_OV_IN,
	input  wire logic        VBUS_UV_IN,
	input  wire logic        VBUS_RV_IN,
	input  wire logic        VCONN_OC_IN,
	input  wire logic        VCONN_OV_IN,
	input  wire logic        VCONN_UV_IN,
	input  wire logic        VCONN_OT_IN,
	input  wire logic        VCONN_RV_IN,
	input  wire logic [15:0] VBUS_LEVEL_IN,
	output logic             SRC_GATE_OUT,
	output logic             SNK_GATE_OUT,
	output logic             VBUS_DISCHARGE_OUT,
	output logic             VCONN_MUX_OUT,
	output logic             VCONN_DISCHARGE_OUT,
	output logic      [1:0]  VBUS_OC_THRESH_OUT,
	output logic      [1:0]  VBUS_OV_THRESH_OUT,
	output logic      [1:0]  VCONN_OC_THRESH_OUT,
	output logic             SINK_DISCONNECT_OUT,
	output logic             FAULT_OUT_N_OUT,
	output logic             ALERT_OUT
);
	localparam int BW = 18;
	if (UV_BLANK_UNIT_CYC < 1 || UV_BLANK_UNIT_CYC * 4 >= (1 << BW)) begin : g_blank_range
		$error("UV_BLANK_UNIT_CYC out of range for blanking counter");
	end

	logic [7:0]  fault_status_mask_ff;
	logic [7:0]  fault_control_ff;
	logic [7:0]  power_control_ff;
	logic [7:0]  fault_status_ff;
	logic [15:0] sink_disconnect_threshold_ff;
	logic [15:0] extra_status_ff;
	logic [15:0] extra_status_alert_mask_ff;
	logic [15:0] vbus_protection_config_ff;
	logic [15:0] vconn_protection_config_ff;
	logic [15:0] fault_output_select_ff;
	logic [7:0]  nxt_fault_status;
	logic [15:0] nxt_extra_status;
	logic        src_off_ff, snk_off_ff, src_req_d_ff, vconn_on_d_ff, src_off_d_ff;
	logic        fault_pin_ff, vbus_dis_ff;
	logic [BW-1:0] vbus_blank_ff, vconn_blank_ff;
	logic        wr_fc, wr_pc, wr_fs, wr_xs;
	logic        vbus_oc, vbus_ov, src_uv, src_rv;
	logic        vconn_oc, vconn_ov, vconn_uv, vconn_ot, vconn_rv;
	logic        vbus_fault, src_kill, snk_kill, vconn_kill, vconn_on;
	logic        pin_set;
	logic [15:0] sel;

	assign sel      = fault_output_select_ff;
	assign vconn_on = power_control_ff[fault_prot_pkg::PC_VCONN_SUPPLY_ON];
	assign wr_fc = REG_WR_IN && REG_ADDR_IN == fault_prot_pkg::OFS_FAULT_CONTROL;
	assign wr_pc = REG_WR_IN && REG_ADDR_IN == fault_prot_pkg::OFS_POWER_CONTROL;
	assign wr_fs = REG_WR_IN && REG_ADDR_IN == fault_prot_pkg::OFS_FAULT_STATUS;
	assign wr_xs = REG_WR_IN && REG_ADDR_IN == fault_prot_pkg::OFS_EXTRA_STATUS;

	// Qualified fault events; each is a level, repeated every cycle it lasts
	always_comb begin
		// [R1] either overcurrent source
		vbus_oc = fault_control_ff[fault_prot_pkg::FC_VBUS_OC_EN]
			&& (CURRENT_SENSE_PAIR_OC_IN || GPIO_OC_IN);
		// [R7] either enable arms it
		vbus_ov = VBUS_OV_IN && (fault_control_ff[fault_prot_pkg::FC_VBUS_OV_EN]
			|| vbus_protection_config_ff[fault_prot_pkg::VB_OV_EN]);
		// [R11] [R12] source role only, blanked after enable
		src_uv = VBUS_UV_IN && SRC_GATE_REQ_IN && src_req_d_ff && vbus_blank_ff == '0
			&& !vbus_protection_config_ff[fault_prot_pkg::VB_UV_DISABLE];
		// [R13] reverse voltage when enabled
		src_rv = VBUS_RV_IN && vbus_protection_config_ff[fault_prot_pkg::VB_RV_EN];
		vconn_oc = VCONN_OC_IN && fault_control_ff[fault_prot_pkg::FC_VCONN_OC_EN];
		vconn_ov = VCONN_OV_IN;
		// [R20] supply on, not disabled, blanking over
		vconn_uv = VCONN_UV_IN && vconn_on && vconn_on_d_ff && vconn_blank_ff == '0
			&& !vconn_protection_config_ff[fault_prot_pkg::VC_UV_DISABLE];
		vconn_ot = VCONN_OT_IN && vconn_protection_config_ff[fault_prot_pkg::VC_OT_EN];
		vconn_rv = VCONN_RV_IN;
	end

	// Shut-off decisions; every applicable action is taken together
	always_comb begin
		vbus_fault = vbus_oc || vbus_ov || src_uv || src_rv;
		// [R2] [R21] [R22] [R25] source gate kill
		src_kill = SRC_GATE_REQ_IN && (vbus_fault || vconn_ot || vconn_rv);
		// [R3] sink gate kill
		snk_kill = SNK_GATE_REQ_IN && (vbus_oc || vbus_ov || vconn_ot || vconn_rv);
		// [R5] [R16] [R18] [R19] [R21] [R22] supply kill
		vconn_kill = (vbus_fault && vconn_on) || vconn_oc || vconn_ov
			|| vconn_uv || vconn_ot || vconn_rv;
	end

	// Status set terms; set wins over a clear in the same cycle
	always_comb begin
		nxt_fault_status = fault_status_ff;
		if (wr_fs)
			nxt_fault_status = fault_status_ff & ~REG_WDATA_IN[7:0];
		// [R4] [R10] [R14] VBUS overcurrent bit and its aliases
		if (vbus_oc
			|| (src_uv && !fault_control_ff[fault_prot_pkg::FC_VBUS_OC_EN]
				&& sel[fault_prot_pkg::SEL_VBUS_UV])
			|| (src_rv && fault_control_ff[fault_prot_pkg::FC_VBUS_OC_EN]
				&& sel[fault_prot_pkg::SEL_VBUS_RV]))
			nxt_fault_status[fault_prot_pkg::FS_VBUS_OC] = 1'b1;
		// [R7] overvoltage bit
		if (vbus_ov)
			nxt_fault_status[fault_prot_pkg::FS_VBUS_OV] = 1'b1;
		// [R16] [R18] [R19] [R22] VCONN overcurrent bit
		if (vconn_oc || (fault_control_ff[fault_prot_pkg::FC_VCONN_OC_EN]
			&& ((vconn_ov && sel[fault_prot_pkg::SEL_VCONN_OV])
			|| (vconn_uv && sel[fault_prot_pkg::SEL_VCONN_UV])
			|| (vconn_rv && sel[fault_prot_pkg::SEL_VCONN_RV]))))
			nxt_fault_status[fault_prot_pkg::FS_VCONN_OC] = 1'b1;
		nxt_extra_status = extra_status_ff;
		if (wr_xs)
			nxt_extra_status = extra_status_ff & ~REG_WDATA_IN;
		// [R9] [R13] [R18] [R19] [R21] [R22] extra status bits
		nxt_extra_status[fault_prot_pkg::XS_SRC_UV]   |= src_uv;
		nxt_extra_status[fault_prot_pkg::XS_SRC_RV]   |= src_rv;
		nxt_extra_status[fault_prot_pkg::XS_VCONN_OV] |= vconn_ov;
		nxt_extra_status[fault_prot_pkg::XS_VCONN_UV] |= vconn_uv;
		nxt_extra_status[fault_prot_pkg::XS_VCONN_OT] |= vconn_ot;
		nxt_extra_status[fault_prot_pkg::XS_VCONN_RV] |= vconn_rv;
	end

	// [R24] sticky status registers
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			fault_status_ff <= 8'h00;
			extra_status_ff <= 16'h0000;
		end else begin
			fault_status_ff <= nxt_fault_status;
			extra_status_ff <= nxt_extra_status;
		end
	end

	// Plain configuration registers; 8-bit ones take the low byte
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			fault_status_mask_ff         <= fault_prot_pkg::RST_FAULT_STATUS_MASK;
			fault_control_ff             <= fault_prot_pkg::RST_FAULT_CONTROL;
			sink_disconnect_threshold_ff <= fault_prot_pkg::RST_SINK_DISC_THRESH;
			extra_status_alert_mask_ff   <= fault_prot_pkg::RST_EXTRA_MASK;
			vbus_protection_config_ff    <= fault_prot_pkg::RST_VBUS_PROT_CONFIG;
			vconn_protection_config_ff   <= fault_prot_pkg::RST_VCONN_PROT_CONFIG;
			fault_output_select_ff       <= fault_prot_pkg::RST_FAULT_OUTPUT_SEL;
		end else if (REG_WR_IN) begin
			unique case (REG_ADDR_IN)
				fault_prot_pkg::OFS_FAULT_STATUS_MASK: fault_status_mask_ff <= REG_WDATA_IN[7:0];
				fault_prot_pkg::OFS_FAULT_CONTROL:     fault_control_ff <= REG_WDATA_IN[7:0];
				fault_prot_pkg::OFS_SINK_DISC_THRESH:  sink_disconnect_threshold_ff <= REG_WDATA_IN;
				fault_prot_pkg::OFS_EXTRA_STATUS_MASK: extra_status_alert_mask_ff <= REG_WDATA_IN;
				fault_prot_pkg::OFS_VBUS_PROT_CONFIG:  vbus_protection_config_ff <= REG_WDATA_IN;
				fault_prot_pkg::OFS_VCONN_PROT_CONFIG: vconn_protection_config_ff <= REG_WDATA_IN;
				fault_prot_pkg::OFS_FAULT_OUTPUT_SEL:  fault_output_select_ff <= REG_WDATA_IN;
				default: ;
			endcase
		end
	end

	// Power control: a fault clearing the supply beats a software write
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			power_control_ff <= fault_prot_pkg::RST_POWER_CONTROL;
		end else begin
			if (wr_pc)
				power_control_ff <= REG_WDATA_IN[7:0];
			// [R5] [R16] supply enable cleared
			if (vconn_kill)
				power_control_ff[fault_prot_pkg::PC_VCONN_SUPPLY_ON] <= 1'b0;
		end
	end

	// Gate shut-off latches hold until the path request is withdrawn
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			src_off_ff    <= 1'b0;
			src_off_d_ff  <= 1'b0;
			vbus_dis_ff   <= 1'b0;
			snk_off_ff    <= 1'b0;
			src_req_d_ff  <= 1'b0;
			vconn_on_d_ff <= 1'b0;
		end else begin
			// [R2] source gate latch, then one discharge pulse
			src_off_ff    <= SRC_GATE_REQ_IN && (src_off_ff || src_kill);
			src_off_d_ff  <= src_off_ff;
			vbus_dis_ff   <= src_off_ff && !src_off_d_ff;
			// [R3] sink gate latch
			snk_off_ff    <= SNK_GATE_REQ_IN && (snk_off_ff || snk_kill);
			src_req_d_ff  <= SRC_GATE_REQ_IN;
			vconn_on_d_ff <= vconn_on;
		end
	end

	// Blanking counters start on the enable edge; select picks 1..4 units
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			vbus_blank_ff  <= '0;
			vconn_blank_ff <= '0;
		end else begin
			// [R11] VBUS blanking
			if (SRC_GATE_REQ_IN && !src_req_d_ff)
				vbus_blank_ff <= BW'(UV_BLANK_UNIT_CYC) * BW'(32'(vbus_protection_config_ff[
					fault_prot_pkg::VB_UV_BLANK_LSB +: 2]) + 1);
			else if (vbus_blank_ff != '0)
				vbus_blank_ff <= vbus_blank_ff - 1'b1;
			// [R20] VCONN blanking
			if (vconn_on && !vconn_on_d_ff)
				vconn_blank_ff <= BW'(UV_BLANK_UNIT_CYC) * BW'(32'(vconn_protection_config_ff[
					fault_prot_pkg::VC_UV_BLANK_LSB +: 2]) + 1);
			else if (vconn_blank_ff != '0)
				vconn_blank_ff <= vconn_blank_ff - 1'b1;
		end
	end

	// Fault pin: any selected event pulls it low
	always_comb begin
		pin_set = (vbus_oc && sel[fault_prot_pkg::SEL_VBUS_OC])
			|| (vbus_ov && sel[fault_prot_pkg::SEL_VBUS_OV])
			|| (src_uv && sel[fault_prot_pkg::SEL_SRC_UV])
			|| (src_rv && sel[fault_prot_pkg::SEL_VBUS_RV])
			|| (vconn_oc && sel[fault_prot_pkg::SEL_VCONN_OC])
			|| (vconn_ov && sel[fault_prot_pkg::SEL_VCONN_OV])
			|| (vconn_uv && sel[fault_prot_pkg::SEL_VCONN_UV])
			|| (vconn_ot && sel[fault_prot_pkg::SEL_VCONN_OT])
			|| (vconn_rv && sel[fault_prot_pkg::SEL_VCONN_RV]);
	end

	// [R23] released only once both status registers are empty
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN)
			fault_pin_ff <= 1'b0;
		else if (pin_set)
			fault_pin_ff <= 1'b1;
		else if (nxt_fault_status == 8'h00 && nxt_extra_status == 16'h0000)
			fault_pin_ff <= 1'b0;
	end

	// Register read port, answered one cycle after the strobe
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			REG_RDATA_OUT <= 16'h0000;
		end else if (REG_RD_IN) begin
			unique case (REG_ADDR_IN)
				fault_prot_pkg::OFS_FAULT_STATUS_MASK: REG_RDATA_OUT <= {8'h00, fault_status_mask_ff};
				fault_prot_pkg::OFS_FAULT_CONTROL:     REG_RDATA_OUT <= {8'h00, fault_control_ff};
				fault_prot_pkg::OFS_POWER_CONTROL:     REG_RDATA_OUT <= {8'h00, power_control_ff};
				fault_prot_pkg::OFS_FAULT_STATUS:      REG_RDATA_OUT <= {8'h00, fault_status_ff};
				fault_prot_pkg::OFS_SINK_DISC_THRESH:  REG_RDATA_OUT <= sink_disconnect_threshold_ff;
				fault_prot_pkg::OFS_EXTRA_STATUS:      REG_RDATA_OUT <= extra_status_ff;
				fault_prot_pkg::OFS_EXTRA_STATUS_MASK: REG_RDATA_OUT <= extra_status_alert_mask_ff;
				fault_prot_pkg::OFS_VBUS_PROT_CONFIG:  REG_RDATA_OUT <= vbus_protection_config_ff;
				fault_prot_pkg::OFS_VCONN_PROT_CONFIG: REG_RDATA_OUT <= vconn_protection_config_ff;
				fault_prot_pkg::OFS_FAULT_OUTPUT_SEL:  REG_RDATA_OUT <= fault_output_select_ff;
				default:                               REG_RDATA_OUT <= 16'h0000;
			endcase
		end
	end

	// Outputs; discharge pulses follow the gate or mux turning off
	always_comb begin
		SRC_GATE_OUT        = SRC_GATE_REQ_IN && !src_off_ff;
		SNK_GATE_OUT        = SNK_GATE_REQ_IN && !snk_off_ff;
		// [R2] discharge one cycle after gate off
		VBUS_DISCHARGE_OUT  = vbus_dis_ff;
		VCONN_MUX_OUT       = vconn_on;
		VCONN_DISCHARGE_OUT = vconn_on_d_ff && !vconn_on;
		// [R6] overcurrent threshold code
		VBUS_OC_THRESH_OUT  = vbus_protection_config_ff[fault_prot_pkg::VB_OC_THR_LSB +: 2];
		// [R8] sink role has no default code; it falls to standard max
		VBUS_OV_THRESH_OUT  = vbus_protection_config_ff[fault_prot_pkg::VB_OV_THR_LSB +: 2];
		if (SNK_GATE_REQ_IN && VBUS_OV_THRESH_OUT == fault_prot_pkg::OV_THR_DEFAULT)
			VBUS_OV_THRESH_OUT = fault_prot_pkg::OV_THR_STD_MAX;
		// [R17] VCONN threshold, illegal code falls to default
		VCONN_OC_THRESH_OUT = vconn_protection_config_ff[fault_prot_pkg::VC_OC_THR_LSB +: 2];
		if (VCONN_OC_THRESH_OUT > fault_prot_pkg::VC_OC_THR_MAXCD)
			VCONN_OC_THRESH_OUT = 2'h0;
		// [R12] sink disconnect compare
		SINK_DISCONNECT_OUT = SNK_GATE_REQ_IN && VBUS_LEVEL_IN < sink_disconnect_threshold_ff;
		FAULT_OUT_N_OUT     = !fault_pin_ff;
		// [R24] masked alert
		ALERT_OUT = |(fault_status_ff & fault_status_mask_ff)
			|| |(extra_status_ff & extra_status_alert_mask_ff);
	end

	// Checks
	chk_vbus_oc_sticky: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN) // [R4]
		vbus_oc |=> fault_status_ff[fault_prot_pkg::FS_VBUS_OC])
		else $error("VBUS overcurrent bit not set");
	chk_src_gate_off: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN) // [R2]
		src_kill ##1 SRC_GATE_REQ_IN |-> !SRC_GATE_OUT)
		else $error("Source gate stayed on after fault");
	chk_snk_gate_off: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN) // [R3]
		snk_kill ##1 SNK_GATE_REQ_IN |-> !SNK_GATE_OUT)
		else $error("Sink gate stayed on after fault");
	chk_vconn_cleared: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN) // [R5]
		(vbus_fault && vconn_on) |=> !VCONN_MUX_OUT && VCONN_DISCHARGE_OUT)
		else $error("VCONN not shut off on VBUS fault");
	chk_uv_alias: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN) // [R10]
		src_uv && !fault_control_ff[fault_prot_pkg::FC_VBUS_OC_EN]
		&& sel[fault_prot_pkg::SEL_VBUS_UV] |=> fault_status_ff[fault_prot_pkg::FS_VBUS_OC])
		else $error("Undervoltage did not set overcurrent bit");
	chk_uv_blanked: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN) // [R11]
		$rose(SRC_GATE_REQ_IN) |-> !src_uv [*2])
		else $error("Undervoltage seen inside blanking");
	chk_vconn_oc_set: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN) // [R16]
		vconn_oc |=> fault_status_ff[fault_prot_pkg::FS_VCONN_OC] && !VCONN_MUX_OUT)
		else $error("VCONN overcurrent action missing");
	chk_ot_extra: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN) // [R21]
		vconn_ot |=> extra_status_ff[fault_prot_pkg::XS_VCONN_OT])
		else $error("Over-temperature bit not set");
	chk_pin_hold: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN) // [R23]
		!FAULT_OUT_N_OUT && (nxt_fault_status != 8'h00 || nxt_extra_status != 16'h0000)
		|=> !FAULT_OUT_N_OUT)
		else $error("Fault pin released with status pending");
	chk_pin_selected: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN) // [R7]
		vbus_ov && sel[fault_prot_pkg::SEL_VBUS_OV] |=> !FAULT_OUT_N_OUT)
		else $error("Fault pin not driven for selected overvoltage");
endmodule

// ### dv/port_manager_model.sv
// Port manager model: owns the register port of the fault-protection block.
// Assumes the bench clock; every access starts just after a rising edge.
`timescale 1ns/1ps
module port_manager_model (
	input  wire logic        clk_in,
	output logic      [7:0]  addr_out,
	output logic      [15:0] wdata_out,
	output logic             wr_out,
	output logic             rd_out,
	input  wire logic [15:0] rdata_in
);
	// Idle bus with both strobes low from time zero
	initial begin
		addr_out = 8'h00;
		wdata_out = 16'h0000;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end

	// One-cycle write; released lines show the inverse so stale data never passes
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_in);
		#1;
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		@(posedge clk_in);
		#1;
		wr_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~d;
	endtask

	// One-cycle read; data is registered at the strobe edge and then holds
	task automatic rd(input logic [7:0] a, output logic [15:0] q);
		@(posedge clk_in);
		#1;
		addr_out = a;
		rd_out = 1'b1;
		@(posedge clk_in);
		#1;
		rd_out = 1'b0;
		addr_out = ~a;
		q = rdata_in;
	endtask
endmodule

// ### dv/tb.sv
// Self-checking bench for the port fault-protection block.
// Assumes a short blanking unit of 4 cycles so source undervoltage tests stay brief.
`timescale 1ns/1ps
module tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        src_req = 1'b0;
	logic        snk_req = 1'b0;
	logic [9:0]  ev = 10'h000; // cs,gpio,vov,vuv,vrv,coc,cov,cuv,cot,crv
	logic [15:0] lvl = 16'h0050;
	logic [15:0] wdata, rdata, q;
	logic [7:0]  addr;
	logic        wr, rd;
	logic        src_g, snk_g, vb_dis, mux, vc_dis, snk_disc, flt_n, alert;
	logic [1:0]  voc_t, vov_t, coc_t;
	int          mismatches = 0;
	int          check_count = 0;
	int          vc[4] = '{4, 3, 1, 0};

	// Clock at 40 MHz
	always #12.5 clk = ~clk;

	usbc_port_fault_protection #(.UV_BLANK_UNIT_CYC(4)) usbc_port_fault_protection_i (
		.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
		.REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .SRC_GATE_REQ_IN(src_req),
		.SNK_GATE_REQ_IN(snk_req), .CURRENT_SENSE_PAIR_OC_IN(ev[9]), .GPIO_OC_IN(ev[8]),
		.VBUS_OV_IN(ev[7]), .VBUS_UV_IN(ev[6]), .VBUS_RV_IN(ev[5]), .VCONN_OC_IN(ev[4]),
		.VCONN_OV_IN(ev[3]), .VCONN_UV_IN(ev[2]), .VCONN_OT_IN(ev[1]), .VCONN_RV_IN(ev[0]),
		.VBUS_LEVEL_IN(lvl), .SRC_GATE_OUT(src_g), .SNK_GATE_OUT(snk_g),
		.VBUS_DISCHARGE_OUT(vb_dis), .VCONN_MUX_OUT(mux), .VCONN_DISCHARGE_OUT(vc_dis),
		.VBUS_OC_THRESH_OUT(voc_t), .VBUS_OV_THRESH_OUT(vov_t), .VCONN_OC_THRESH_OUT(coc_t),
		.SINK_DISCONNECT_OUT(snk_disc), .FAULT_OUT_N_OUT(flt_n), .ALERT_OUT(alert));

	port_manager_model port_manager_model_i (.clk_in(clk), .addr_out(addr),
		.wdata_out(wdata), .wr_out(wr), .rd_out(rd), .rdata_in(rdata));

	// Compare and count; case inequality so unknowns never match
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// One-cycle comparator event; returns one cycle after the outputs react
	task automatic fire(input int i);
		ev[i] = 1'b1;
		@(posedge clk);
		#1;
		ev[i] = 1'b0;
		@(posedge clk);
		#1;
	endtask

	task automatic t_reset();
		port_manager_model_i.rd(8'h1B, q); check(q, 16'h0007);
		port_manager_model_i.rd(8'hA4, q); check(q, 16'h0050);
		port_manager_model_i.rd(8'hA6, q); check(q, 16'h0008);
		port_manager_model_i.rd(8'h30, q); check(q, 16'h0000);
		check(voc_t, 2'h0);
		check(coc_t, 2'h0);
		check(vov_t, 2'h0);
		check(flt_n, 1'b1);
	endtask

	// Source overvoltage with supply on: gate, discharge, supply, pin, alert
	task automatic t_src_ov();
		port_manager_model_i.wr(8'hA8, 16'h0002);
		port_manager_model_i.wr(8'h1C, 16'h0001);
		port_manager_model_i.wr(8'h15, 16'h0004);
		src_req = 1'b1;
		fire(7);
		check(src_g, 1'b0);
		check(vb_dis, 1'b1);
		check(flt_n, 1'b0);
		check(mux, 1'b0);
		check(alert, 1'b1);
		port_manager_model_i.rd(8'h1F, q); check(q, 16'h0004);
		port_manager_model_i.rd(8'h1C, q); check(q, 16'h0000);
		port_manager_model_i.wr(8'h1F, 16'h0004);
		port_manager_model_i.rd(8'h1F, q); check(q, 16'h0000);
		check(flt_n, 1'b1);
		check(alert, 1'b0);
		src_req = 1'b0;
	endtask

	// Sink overcurrent from both sources, pin not selected; sink disconnect compare
	task automatic t_sink_oc();
		snk_req = 1'b1;
		port_manager_model_i.wr(8'h72, 16'h0100);
		check(snk_disc, 1'b1);
		check(vov_t, 2'h1);
		fire(8);
		check(snk_g, 1'b0);
		check(flt_n, 1'b1);
		port_manager_model_i.rd(8'h1F, q); check(q, 16'h0008);
		port_manager_model_i.wr(8'h1F, 16'h0008);
		fire(9);
		port_manager_model_i.rd(8'h1F, q); check(q, 16'h0008);
		port_manager_model_i.wr(8'h1F, 16'h0008);
		snk_req = 1'b0;
	endtask

	// Undervoltage present from the enable edge is ignored until blanking ends;
	// overcurrent enable off so the undervoltage alias bit shows
	task automatic t_uv_blank();
		port_manager_model_i.wr(8'hA8, 16'h000C);
		port_manager_model_i.wr(8'h1B, 16'h0003);
		src_req = 1'b1;
		ev[6] = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check(flt_n, 1'b1);
		repeat (6) @(posedge clk);
		#1;
		ev[6] = 1'b0;
		check(flt_n, 1'b0);
		port_manager_model_i.rd(8'hA0, q); check(q, 16'h0001);
		port_manager_model_i.rd(8'h1F, q); check(q, 16'h0008);
		port_manager_model_i.wr(8'hA0, 16'h0001);
		port_manager_model_i.wr(8'h1F, 16'h0008);
		src_req = 1'b0;
	endtask

	// Supply overcurrent, overvoltage, over-temperature and reverse each turn the mux off; statuses accumulate
	task automatic t_vconn();
		foreach (vc[k]) begin
			port_manager_model_i.wr(8'h1C, 16'h0001);
			fire(vc[k]);
			check(mux, 1'b0);
		end
		port_manager_model_i.wr(8'h1C, 16'h0001);
		port_manager_model_i.wr(8'h1C, 16'h0000);
		check(vc_dis, 1'b1);
		port_manager_model_i.rd(8'hA0, q); check(q, 16'h0034);
		port_manager_model_i.rd(8'h1F, q); check(q, 16'h0002);
	endtask

	// Watchdog ends a hung run
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		finish_test();
	end

	initial begin
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		t_reset();
		t_src_ov();
		t_sink_oc();
		t_uv_blank();
		t_vconn();
		finish_test();
	end
endmodule
